// file: hdl/dcr_pkg.sv
package dcr_pkg;
    localparam int ADDR_W = 16;
    localparam int CNT_W = 14;
    localparam logic [11:0] OFF_PERIPH_ADDR = 12'h000;
    localparam logic [11:0] OFF_XFER_COUNT = 12'h004;
    localparam logic [15:0] RST_PERIPH_ADDR = 16'h0000;
    localparam logic [13:0] RST_XFER_COUNT = 14'h0000;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic [15:0] periph_addr;
        logic [13:0] transfer_count_field;
        logic [14:0] total_transfers;
    } dcr_seq_s;
endpackage : dcr_pkg

// file: hdl/dcr_word_reg.sv
`timescale 1ns/1ps
module dcr_word_reg #(
    parameter int W = 16,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_en,
    input wire logic [W-1:0] wr_data,
    output logic [W-1:0] q
);
    logic [W-1:0] q_nxt;

    always_comb begin
        q_nxt = q;
        if (wr_en) begin
            q_nxt = wr_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= RST;
        end else begin
            q <= q_nxt;
        end
    end
endmodule : dcr_word_reg

// file: hdl/dcr_regs.sv
`timescale 1ns/1ps
// Overview of operation
// - 16-bit read/write peripheral address register, cleared at reset, drives channel address.
// - 14-bit read/write transfer count field in bits 13:0, cleared at reset.
// - Channel performs count field plus one transfers; zero means one transfer.
// - Count bits 15:14 read zero and ignore writes.
module dcr_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic chan_active,
    output dcr_pkg::dcr_seq_s seq_out,
    output logic wr_while_active
);
    logic [15:0] addr_q;
    logic [13:0] cnt_q;
    logic wr_addr;
    logic wr_cnt;
    logic hit;
    logic [31:0] prdata_nxt;
    logic pslverr_nxt;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic wr_while_active_nxt;
    logic wr_while_active_r;
    logic setup;
    logic wr_go;
    logic [31:0] rd_word;
    logic [14:0] total_nxt;
    logic [14:0] total_r;

    // Read data is loaded in the setup cycle; a write lands only at the access edge where pready is high.
    assign setup = psel && !penable;
    assign wr_go = psel && penable && pready && pwrite;

    always_comb begin
        wr_addr = 1'b0;
        wr_cnt = 1'b0;
        hit = 1'b1;
        rd_word = dcr_pkg::RD_ZERO;
        if (paddr == dcr_pkg::OFF_PERIPH_ADDR) begin
            wr_addr = wr_go;
            rd_word = {16'h0000, addr_q};
        end else if (paddr == dcr_pkg::OFF_XFER_COUNT) begin
            wr_cnt = wr_go;
            rd_word = {18'h00000, cnt_q};
        end else begin
            hit = 1'b0;
        end
        prdata_nxt = prdata_r;
        pslverr_nxt = pslverr_r;
        if (setup) begin
            prdata_nxt = pwrite ? dcr_pkg::RD_ZERO : rd_word;
            pslverr_nxt = !hit;
        end
        total_nxt = total_r;
        if (wr_cnt) begin
            total_nxt = {1'b0, pwdata[13:0]} + 15'h0001;
        end
        // Software is trusted not to do this; the flag only reports it.
        wr_while_active_nxt = (wr_addr || wr_cnt) && chan_active;
    end

    dcr_word_reg #(.W(dcr_pkg::ADDR_W), .RST(dcr_pkg::RST_PERIPH_ADDR)) u_addr (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_addr),
        .wr_data(pwdata[15:0]),
        .q(addr_q)
    );

    dcr_word_reg #(.W(dcr_pkg::CNT_W), .RST(dcr_pkg::RST_XFER_COUNT)) u_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_cnt),
        .wr_data(pwdata[13:0]),
        .q(cnt_q)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= dcr_pkg::RD_ZERO;
            pslverr_r <= 1'b0;
            wr_while_active_r <= 1'b0;
            total_r <= {1'b0, dcr_pkg::RST_XFER_COUNT} + 15'h0001;
        end else begin
            prdata_r <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
            wr_while_active_r <= wr_while_active_nxt;
            total_r <= total_nxt;
        end
    end

    // The setup cycle prepares the answer, so the access phase completes with no wait state.
    assign pready = 1'b1;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    assign wr_while_active = wr_while_active_r;

    always_comb begin
        seq_out.periph_addr = addr_q;
        seq_out.transfer_count_field = cnt_q;
        seq_out.total_transfers = total_r;
    end
endmodule : dcr_regs

// file: dv/dcr_regs_asserts.sv
`timescale 1ns/1ps
module dcr_regs_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic chan_active,
    input wire logic wr_while_active,
    input wire dcr_pkg::dcr_seq_s seq_out
);
    wire wr = psel && penable && pready && pwrite;
    wire mapped = paddr == 12'h000 || paddr == 12'h004;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_ADDR: assert property (wr && paddr == 12'h000
        |=> seq_out.periph_addr == $past(pwdata[15:0])) else $error("addr");
    AST_CNT: assert property (wr && paddr == 12'h004
        |=> seq_out.transfer_count_field == $past(pwdata[13:0])) else $error("cnt");
    AST_TOT: assert property (seq_out.total_transfers == {1'b0, seq_out.transfer_count_field} + 15'h0001)
        else $error("tot");
    AST_HI: assert property (psel && penable && paddr == 12'h004 |-> prdata[31:14] == 18'h00000)
        else $error("hi");
    AST_HOLD: assert property (!wr |=> $stable(seq_out)) else $error("hold");
    AST_ERR: assert property (psel && penable && !mapped |-> pslverr) else $error("err");
    AST_FLAG: assert property (wr && mapped && chan_active |=> wr_while_active)
        else $error("flag");
endmodule : dcr_regs_asserts
bind dcr_regs dcr_regs_asserts dcr_regs_asserts_inst (.*);

// file: dv/dcr_chan_model.sv
`timescale 1ns/1ps
module dcr_chan_model (
    input wire logic pclk,
    input wire logic go,
    output logic chan_active
);
    always @(posedge pclk) chan_active <= go;
endmodule : dcr_chan_model

// file: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, chan_active, pready, pslverr, wr_while_active;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    dcr_pkg::dcr_seq_s seq_out;
    int err_count = 0, compares = 0;
    initial forever #12.5 pclk = ~pclk;
    dcr_regs dcr_regs_inst (.*);
    dcr_chan_model dcr_chan_model_inst (.*);
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask : xfer
    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run
    task automatic t_regs;
        xfer(0, 12'h004, 0);
        chk("cnt_rst", rd, 0);
        xfer(1, 12'h000, 32'hFFFF_A5C3);
        xfer(1, 12'h004, 32'hFFFF_FFFF);
        xfer(0, 12'h004, 0);
        chk("cnt_hi", rd, 32'h3FFF);
        chk("total", 32'(seq_out.total_transfers), 32'h4000);
        go <= 1;
        xfer(0, 12'h000, 0);
        chk("addr", rd, 32'hA5C3);
        chk("seq_addr", 32'(seq_out.periph_addr), 32'hA5C3);
        chk("seq_cnt", 32'(seq_out.transfer_count_field), 32'h0000_3FFF);
        chk("ok_err", {31'h0, pslverr}, 32'h0000_0000);
        go <= 0;
        xfer(1, 12'h004, 0);
        chk("total0", 32'(seq_out.total_transfers), 32'h1);
        chk("no_flag", {31'h0, wr_while_active}, 32'h0000_0000);
        xfer(0, 12'h008, 0);
        chk("unmapped", {31'h0, pslverr}, 32'h1);
        chk("ready", {31'h0, pready}, 32'h0000_0001);
        // A deliberate write while the channel runs exercises the diagnostic flag.
        go <= 1'b1;
        xfer(1'b1, 12'h000, 32'h0000_1234);
        chk("flag", {31'h0, wr_while_active}, 32'h0000_0001);
        go <= 1'b0;
        $display("register test done");
    endtask : t_regs
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        t_regs();
        complete_run();
    end
    initial begin
        #100us;
        err_count++;
        complete_run();
    end
endmodule : tb_top
